/* File: tb_ulm_regs.sv */
// Testbench for the line maintenance register slice.
// Assumes the line model supplies superframe markers.
`timescale 1ns/1ps
`default_nettype none
module tb_ulm_regs;
  import ulm_pkg::*;
  logic clock, nrst, wr, rd, line_transparent, far_auto, superframe;
  logic far_err_evt, near_err_evt, irq;
  logic [7:0] addr, wdata, rdata, irq_mask;
  logic [3:0] line_ind, sys_ind, sent;
  ulm_rx_t rx_maint;
  ulm_evt_t events;
  ulm_op_t auto_op;
  ulm_ctl_t ctl;
  int miscompares = 0;
  int n_compared = 0;

  ulm_regs dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_maint(rx_maint),
    .line_ind(line_ind), .line_transparent(line_transparent),
    .far_auto(far_auto), .superframe(superframe),
    .far_err_evt(far_err_evt), .near_err_evt(near_err_evt),
    .events(events), .auto_op(auto_op), .irq_mask(irq_mask), .ctl(ctl),
    .sys_ind(sys_ind), .irq(irq));
  ulm_line_model line (.clock(clock), .nrst(nrst), .ctl(ctl),
    .superframe(superframe), .sent(sent));

  task automatic complete_run;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), e, rdata);
  endtask : rd_reg

  task automatic wait_sf(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      @(posedge clock);
      #1;
      while (superframe !== 1'b1 && k < 20) begin
        @(posedge clock);
        #1;
        k++;
      end
      if (k == 20) begin
        miscompares++;
        complete_run();
      end
    end
    @(posedge clock);
    #1;
  endtask : wait_sf

  task automatic auto_step(input ulm_op_t o, input logic [7:0] e);
    @(posedge clock);
    auto_op <= o;
    @(posedge clock);
    auto_op <= ULM_OP_NONE;
    rd_reg(ADDR_LOOP, e);
  endtask : auto_step

  task automatic evt_pulse(input ulm_evt_t ev);
    @(posedge clock);
    events <= ev;
    @(posedge clock);
    events <= '0;
    #1;
  endtask : evt_pulse

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    rx_maint = '0; line_ind = 4'h3; line_transparent = 1'b0;
    far_auto = 1'b0; far_err_evt = 1'b0; near_err_evt = 1'b0;
    events = '0; auto_op = ULM_OP_NONE; irq_mask = 8'h00;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rd_reg(ADDR_TEST, RST_TEST);
    rd_reg(ADDR_LOOP, RST_LOOP);
    rd_reg(ADDR_IND_READ, 8'h03);
    rd_reg(8'h50, 8'h00);
    wr_reg(ADDR_LOOP, 8'hff);
    rd_reg(ADDR_LOOP, 8'h7f);
    check("loops", 8'h3e, {2'b00, ctl.first_channel_loop,
      ctl.second_channel_loop, ctl.complete_loop, ctl.loop_direction,
      ctl.loop_transparency, ctl.framer_loop});
    wr_reg(ADDR_TEST, 8'hff);
    rd_reg(ADDR_TEST, 8'h0d);
    check("test", 8'h07, {5'h00, ctl.corrupt_checksum, ctl.level_one,
      ctl.tone_select});
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      far_err_evt <= 1'b1;
      near_err_evt <= (i < 2);
      @(posedge clock);
      far_err_evt <= 1'b0;
      near_err_evt <= 1'b0;
    end
    rd_reg(ADDR_FAR_CNT, 8'h03);
    rd_reg(ADDR_FAR_CNT, 8'h00);
    rd_reg(ADDR_NEAR_CNT, 8'h02);
    rd_reg(ADDR_NEAR_CNT, 8'h00);
    wr_reg(ADDR_SPARE_TX, 8'h05);
    wait_sf(2);
    check("sent auto", 8'h04, {4'h0, sent});
    wr_reg(ADDR_OPERATING_MODE_REG, 8'h02);
    wait_sf(3);
    check("sent host", 8'h05, {4'h0, sent});
    wr_reg(ADDR_CMD_WRITE, 8'h05);
    #1;
    check("cmd off", 8'h00, {7'h00, ctl.host_cmd_valid});
    wr_reg(ADDR_OPERATING_MODE_REG, 8'h03);
    #1;
    check("cmd on", 8'h15, {3'h0, ctl.host_cmd_valid, ctl.host_cmd});
    line_ind <= CODE_ANALOG_LOOP;
    wr_reg(ADDR_LOOP, 8'h00);
    #1;
    check("analog", 8'h01, {7'h00, ctl.analog_loop});
    wr_reg(ADDR_MAINTENANCE_FILTER_REG, 8'h04);
    auto_step(ULM_OP_LOOP1, 8'h19);
    auto_step(ULM_OP_LOOP2, 8'h1b);
    auto_step(ULM_OP_RETURN, 8'h18);
    line_ind <= CODE_ACT_IND;
    line_transparent <= 1'b1;
    wr_reg(ADDR_LOOP, 8'h40);
    #1;
    check("framer ind", {4'h0, CODE_DEACT_CONF}, {4'h0, sys_ind});
    rd_reg(ADDR_IND_READ, {4'h0, CODE_ACT_IND});
    wr_reg(ADDR_LOOP, 8'h34);
    #1;
    check("line ind", {4'h0, CODE_DEACT_CONF}, {4'h0, sys_ind});
    rd_reg(ADDR_IND_READ, {4'h0, CODE_ACT_IND});
    wr_reg(ADDR_LOOP, 8'h14);
    #1;
    check("loop_transparency ind", {4'h0, CODE_ACT_IND}, {4'h0, sys_ind});
    evt_pulse(8'h20);
    check("irq set", 8'h01, {7'h00, irq});
    rd_reg(ADDR_IRQ_STAT, 8'h20);
    rd_reg(ADDR_IRQ_STAT, 8'h00);
    irq_mask <= 8'hff;
    evt_pulse(8'hff);
    check("irq mask", 8'h00, {7'h00, irq});
    rd_reg(ADDR_IRQ_STAT, 8'hff);
    rx_maint <= 7'h2a;
    rd_reg(ADDR_SPARE_RX, 8'h2a);
    complete_run();
  end
endmodule : tb_ulm_regs
`default_nettype wire

/* File: ulm_line_model.sv */
// Line core stand-in: superframe markers, records maintenance bits sent.
// Assumes the register slice control struct on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ulm_line_model
  import ulm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register slice side
  input wire ulm_ctl_t ctl,
  output logic superframe,
  output logic [3:0] sent
);
  logic [2:0] cnt_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 3'h0;
      superframe <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      superframe <= (cnt_reg == 3'h7);
    end
  end

  // Sampled at each marker, so a new value shows one frame late
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sent <= 4'hf;
    end else if (superframe) begin
      sent <= {ctl.spare, ctl.far_bit};
    end
  end
endmodule : ulm_line_model
`default_nettype wire

/* File: ulm_pkg.sv */
// Package for the line maintenance and test register slice.
// Assumes a byte-wide register port and a single 100 MHz clock domain.
package ulm_pkg;
  localparam logic [7:0] ADDR_SPARE_RX = 8'h6b;
  localparam logic [7:0] ADDR_SPARE_TX = 8'h6c;
  localparam logic [7:0] ADDR_IND_READ = 8'h6d;
  localparam logic [7:0] ADDR_CMD_WRITE = 8'h6e;
  localparam logic [7:0] ADDR_TEST = 8'h6f;
  localparam logic [7:0] ADDR_LOOP = 8'h70;
  localparam logic [7:0] ADDR_FAR_CNT = 8'h71;
  localparam logic [7:0] ADDR_NEAR_CNT = 8'h72;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h7a;
  localparam logic [7:0] ADDR_OPERATING_MODE_REG = 8'h7e;
  localparam logic [7:0] ADDR_MAINTENANCE_FILTER_REG = 8'h7f;

  localparam logic [7:0] RST_SPARE_TX = 8'hff;
  localparam logic [7:0] RST_IND = 8'h00;
  localparam logic [7:0] RST_CMD = 8'h01;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_LOOP = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SPARE_RX = 8'h1f;

  // Fixed bits and write masks of the loopback, spare, test and command registers
  localparam logic [7:0] LOOP_FIXED = 8'h08;
  localparam logic [7:0] LOOP_WMASK = 8'h77;
  localparam logic [7:0] SPARE_TX_FIXED = 8'hf0;
  localparam logic [7:0] TEST_WMASK = 8'h0d;
  localparam logic [7:0] CMD_WMASK = 8'h0f;

  // Loopback register bit positions
  localparam int LB_FIRST = 0;
  localparam int LB_SECOND = 1;
  localparam int LB_COMPLETE = 2;
  localparam int LB_DIR = 4;
  localparam int LB_LOOP_TRANSPARENCY = 5;
  localparam int LB_FRAMER = 6;
  // Test register bit positions
  localparam int TS_TONE = 0;
  localparam int TS_LEVEL = 2;
  localparam int TS_CRC = 3;
  // Operating mode bit positions
  localparam int OM_CMD_EN = 0;
  localparam int OM_FAR_EN = 1;
  // Filter field
  localparam logic [2:0] FILT_AUTO = 3'b100;

  // Indication codes, four bits
  localparam logic [3:0] CODE_ANALOG_LOOP = 4'h8;
  localparam logic [3:0] CODE_DEACT_CONF = 4'hf;
  localparam logic [3:0] CODE_ACT_IND = 4'hc;

  typedef enum logic [1:0] {
    ULM_OP_NONE,
    ULM_OP_LOOP1,
    ULM_OP_LOOP2,
    ULM_OP_RETURN
  } ulm_op_t;

  // Events from the line core
  typedef struct packed {
    logic maint_test;
    logic ind_change;
    logic block_err;
    logic spare_change;
    logic m4_change;
    logic op_msg;
    logic tick_6ms;
    logic sf_12ms;
  } ulm_evt_t;

  // Received maintenance data from the line core
  typedef struct packed {
    logic [1:0] mlt_state;
    logic near_ok;
    logic [2:0] spare;
    logic far_ok;
  } ulm_rx_t;

  // Controls to the line core and system interface
  typedef struct packed {
    logic [2:0] spare;
    logic far_bit;
    logic corrupt_checksum;
    logic level_one;
    logic tone_select;
    logic framer_loop;
    logic first_channel_loop;
    logic second_channel_loop;
    logic complete_loop;
    logic loop_direction;
    logic loop_transparency;
    logic analog_loop;
    logic host_cmd_valid;
    logic [3:0] host_cmd;
  } ulm_ctl_t;
endpackage : ulm_pkg

/* File: ulm_regs.sv */
// Maintenance and test register slice of a 2B1Q line transceiver.
// Assumes line core events are synchronous one-cycle pulses on clock.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Received near error bit low means error
// - Far error bit active low both ways
// - Spare write latched, repeated every superframe
// - Host far bit only when mode bit set
// - Spare bits only carried, no effect
// - Indication read returns state machine code
// - Host command effective only when enabled
// - Corrupt checksum bit inverts sent CRC
// - Level bit selects one or three pulses
// - Tone bit: single pulses or 40 kHz
// - Analog loop closed by command code; the code decodes it from the line_ind indication instead
// - Automatic filter mode edits loop register
// - Framer loop needs other loop bits zero
// - Transparency idles forwarded data in loops
// - One direction bit for all loops
// - Bits 0..2 close channel and complete loops
// - Framer loop system side sends deactivation
// - Nontransparent complete line loop sends deactivation
// - Far counter clears on read
// - Near counter clears on read
// - Interrupt status flags, masked onto request
module ulm_regs
  import ulm_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Line core
  input wire ulm_rx_t rx_maint,
  input wire logic [3:0] line_ind,
  input wire logic line_transparent,
  input wire logic far_auto,
  input wire logic superframe,
  input wire logic far_err_evt,
  input wire logic near_err_evt,
  input wire ulm_evt_t events,
  input wire ulm_op_t auto_op,
  input wire logic [7:0] irq_mask,
  output ulm_ctl_t ctl,
  output logic [3:0] sys_ind,
  output logic irq
);
  logic [7:0] spare_tx_reg, spare_live_reg;
  logic [7:0] cmd_reg, test_reg, loop_reg;
  logic [7:0] operating_mode_reg_reg, maintenance_filter_reg_reg, irq_reg;
  logic [CNT_W-1:0] far_cnt_reg, near_cnt_reg;
  logic [7:0] rdata_reg;
  logic [7:0] loop_next;
  logic wr_loop, rd_far, rd_near, auto_mode, sys_loop_idle;

  assign auto_mode = maintenance_filter_reg_reg[2:0] == FILT_AUTO;
  assign wr_loop = wr && addr == ADDR_LOOP;
  assign rd_far = rd && addr == ADDR_FAR_CNT;
  assign rd_near = rd && addr == ADDR_NEAR_CNT;

  // Host settings
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      spare_tx_reg <= RST_SPARE_TX;
      cmd_reg <= RST_CMD;
      test_reg <= RST_TEST;
      operating_mode_reg_reg <= RST_ZERO;
      maintenance_filter_reg_reg <= RST_ZERO;
    end else if (wr) begin
      unique case (addr)
        ADDR_SPARE_TX: spare_tx_reg <= wdata | SPARE_TX_FIXED;
        ADDR_CMD_WRITE: cmd_reg <= wdata & CMD_WMASK;
        ADDR_TEST: test_reg <= wdata & TEST_WMASK;
        ADDR_OPERATING_MODE_REG: operating_mode_reg_reg <= wdata;
        ADDR_MAINTENANCE_FILTER_REG: maintenance_filter_reg_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Spare value is picked up only at superframe start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      spare_live_reg <= RST_SPARE_TX;
    end else if (superframe) begin
      spare_live_reg <= spare_tx_reg;
    end
  end

  // Automatic mode edits win over a host write in the same cycle
  always_comb begin
    loop_next = loop_reg;
    if (wr_loop) begin
      loop_next = (wdata & LOOP_WMASK) | LOOP_FIXED;
    end
    if (auto_mode) begin
      unique case (auto_op)
        ULM_OP_LOOP1: begin
          loop_next[LB_DIR] = 1'b1;
          loop_next[LB_FIRST] = 1'b1;
        end
        ULM_OP_LOOP2: begin
          loop_next[LB_DIR] = 1'b1;
          loop_next[LB_SECOND] = 1'b1;
        end
        ULM_OP_RETURN: begin
          loop_next[LB_FIRST] = 1'b0;
          loop_next[LB_SECOND] = 1'b0;
          loop_next[LB_COMPLETE] = 1'b0;
        end
        ULM_OP_NONE: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      loop_reg <= RST_LOOP;
    end else begin
      loop_reg <= loop_next;
    end
  end

  // Counters: an error in the read cycle starts the new count at one
  ulm_err_counter #(
    .W(CNT_W)
  ) far_counter (
    .clock(clock),
    .nrst(nrst),
    .evt(far_err_evt),
    .clr(rd_far),
    .count(far_cnt_reg)
  );

  ulm_err_counter #(
    .W(CNT_W)
  ) near_counter (
    .clock(clock),
    .nrst(nrst),
    .evt(near_err_evt),
    .clr(rd_near),
    .count(near_cnt_reg)
  );

  // Status flags clear on read; a new event in that cycle survives
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= RST_ZERO;
    end else if (rd && addr == ADDR_IRQ_STAT) begin
      irq_reg <= events;
    end else begin
      irq_reg <= irq_reg | events;
    end
  end

  assign irq = |(irq_reg & ~irq_mask);

  // Read data, one cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= RST_ZERO;
    end else if (rd) begin
      unique case (addr)
        ADDR_SPARE_RX: rdata_reg <= {1'b0, rx_maint};
        ADDR_IND_READ: rdata_reg <= {4'h0, line_ind};
        ADDR_TEST: rdata_reg <= test_reg;
        ADDR_LOOP: rdata_reg <= loop_reg;
        ADDR_FAR_CNT: rdata_reg <= 8'(far_cnt_reg);
        ADDR_NEAR_CNT: rdata_reg <= 8'(near_cnt_reg);
        ADDR_IRQ_STAT: rdata_reg <= irq_reg;
        ADDR_OPERATING_MODE_REG: rdata_reg <= operating_mode_reg_reg;
        ADDR_MAINTENANCE_FILTER_REG: rdata_reg <= maintenance_filter_reg_reg;
        default: rdata_reg <= RST_ZERO;
      endcase
    end else begin
      rdata_reg <= RST_ZERO;
    end
  end
  assign rdata = rdata_reg;

  // Framer loop is only honoured with the other loops open
  assign sys_loop_idle = !loop_reg[LB_FIRST] && !loop_reg[LB_SECOND]
                         && !loop_reg[LB_COMPLETE] && !loop_reg[LB_DIR];

  always_comb begin
    ctl.spare = spare_live_reg[3:1];
    ctl.far_bit = operating_mode_reg_reg[OM_FAR_EN] ? spare_live_reg[0] : far_auto;
    ctl.corrupt_checksum = test_reg[TS_CRC];
    ctl.level_one = test_reg[TS_LEVEL];
    ctl.tone_select = test_reg[TS_TONE];
    ctl.framer_loop = loop_reg[LB_FRAMER] && sys_loop_idle;
    ctl.first_channel_loop = loop_reg[LB_FIRST];
    ctl.second_channel_loop = loop_reg[LB_SECOND];
    ctl.complete_loop = loop_reg[LB_COMPLETE];
    ctl.loop_direction = loop_reg[LB_DIR];
    ctl.loop_transparency = loop_reg[LB_LOOP_TRANSPARENCY];
    ctl.analog_loop = line_ind == CODE_ANALOG_LOOP;
    ctl.host_cmd_valid = operating_mode_reg_reg[OM_CMD_EN];
    ctl.host_cmd = cmd_reg[3:0];
  end

  // System side indication substitution
  always_comb begin
    sys_ind = line_ind;
    if (line_transparent && line_ind == CODE_ACT_IND) begin
      if (ctl.framer_loop) begin
        sys_ind = CODE_DEACT_CONF;
      end else if (loop_reg[LB_COMPLETE] && loop_reg[LB_DIR]
                   && loop_reg[LB_LOOP_TRANSPARENCY]) begin
        sys_ind = CODE_DEACT_CONF;
      end
    end
  end

  chk_far_clear: assert property (@(posedge clock) disable iff (!nrst)
    rd_far && !far_err_evt |=> far_cnt_reg == '0)
    else $error("far counter not cleared by read");
  chk_near_clear: assert property (@(posedge clock) disable iff (!nrst)
    rd_near && !near_err_evt |=> near_cnt_reg == '0)
    else $error("near counter not cleared by read");
  chk_far_owner: assert property (@(posedge clock) disable iff (!nrst)
    !operating_mode_reg_reg[OM_FAR_EN] |-> ctl.far_bit == far_auto)
    else $error("far bit not device controlled");
  chk_cmd_gate: assert property (@(posedge clock) disable iff (!nrst)
    wr && addr == ADDR_OPERATING_MODE_REG |=>
      ctl.host_cmd_valid == $past(wdata[OM_CMD_EN]))
    else $error("host command gate wrong");
  sequence s_spare_write;
    wr && addr == ADDR_SPARE_TX && !superframe;
  endsequence
  chk_spare_hold: assert property (@(posedge clock) disable iff (!nrst)
    s_spare_write ##1 superframe |=> spare_live_reg == $past(spare_tx_reg))
    else $error("spare value not sent at superframe");
  chk_framer_gate: assert property (@(posedge clock) disable iff (!nrst)
    ctl.framer_loop |-> loop_reg[2:0] == 3'h0 && !loop_reg[LB_DIR])
    else $error("framer loop with other loops set");
  chk_auto_return: assert property (@(posedge clock) disable iff (!nrst)
    auto_mode && auto_op == ULM_OP_RETURN |=> loop_reg[2:0] == 3'h0)
    else $error("return did not open loops");
  chk_irq_sticky: assert property (@(posedge clock) disable iff (!nrst)
    events.block_err |=> irq_reg[5])
    else $error("block error flag not set");
  chk_ind_read: assert property (@(posedge clock) disable iff (!nrst)
    rd && addr == ADDR_IND_READ |=> rdata == {4'h0, $past(line_ind)})
    else $error("indication read wrong");

  // Assertions below use the module's one clock and reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_loop1_op;
    auto_mode && auto_op == ULM_OP_LOOP1;
  endsequence
  sequence s_loop2_op;
    auto_mode && auto_op == ULM_OP_LOOP2;
  endsequence
  sequence s_host_loop_write;
    !auto_mode && wr_loop;
  endsequence
  sequence s_irq_read_quiet;
    rd && addr == ADDR_IRQ_STAT && events == '0;
  endsequence
  sequence s_act_transparent;
    line_transparent && line_ind == CODE_ACT_IND;
  endsequence

  // Loop register edits, automatic and host
  chk_auto_loop1: assert property (
    s_loop1_op |=> loop_reg[LB_DIR] && loop_reg[LB_FIRST])
    else $error("first channel loop not set by command");
  chk_auto_loop2: assert property (
    s_loop2_op |=> loop_reg[LB_DIR] && loop_reg[LB_SECOND])
    else $error("second channel loop not set by command");
  chk_loop_write: assert property (
    s_host_loop_write |=>
      loop_reg == (($past(wdata) & LOOP_WMASK) | LOOP_FIXED))
    else $error("loop register write wrong");
  chk_loop_hold: assert property (
    !wr_loop && (!auto_mode || auto_op == ULM_OP_NONE) |=>
      $stable(loop_reg))
    else $error("loop register changed on its own");
  chk_loop_fixed: assert property (
    (loop_reg & ~LOOP_WMASK) == LOOP_FIXED)
    else $error("fixed loop register bits changed");

  // Host written registers
  chk_test_write: assert property (
    wr && addr == ADDR_TEST |=> test_reg == ($past(wdata) & TEST_WMASK))
    else $error("test register write wrong");
  chk_cmd_write: assert property (
    wr && addr == ADDR_CMD_WRITE |=>
      cmd_reg == ($past(wdata) & CMD_WMASK))
    else $error("command register write wrong");
  chk_spare_fixed: assert property (
    (spare_tx_reg & SPARE_TX_FIXED) == SPARE_TX_FIXED)
    else $error("spare register upper bits not ones");
  chk_spare_steady: assert property (
    !superframe |=> spare_live_reg == $past(spare_live_reg))
    else $error("sent spare value changed mid superframe");
  chk_far_host: assert property (
    operating_mode_reg_reg[OM_FAR_EN] |-> ctl.far_bit == spare_live_reg[0])
    else $error("far bit not host controlled");

  // Status flags and read port
  chk_irq_clear: assert property (
    s_irq_read_quiet |=> irq_reg == RST_ZERO)
    else $error("status flags not cleared by read");
  chk_irq_masked: assert property (
    irq_mask == '1 |-> !irq)
    else $error("masked flag raised request");
  chk_rdata_idle: assert property (
    !rd |=> rdata == RST_ZERO)
    else $error("read data outside read slot");

  // System side indication
  chk_sys_framer: assert property (
    s_act_transparent ##0 ctl.framer_loop |-> sys_ind == CODE_DEACT_CONF)
    else $error("framer loop indication not substituted");
  chk_sys_loop_transparency: assert property (
    s_act_transparent ##0 !ctl.framer_loop && !loop_reg[LB_LOOP_TRANSPARENCY] |->
      sys_ind == CODE_ACT_IND)
    else $error("transparent loop indication substituted");
  chk_sys_pass: assert property (
    line_ind != CODE_ACT_IND |-> sys_ind == line_ind)
    else $error("indication not passed through");
endmodule : ulm_regs

// Saturating error counter; a read restarts it
module ulm_err_counter
  import ulm_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Event and read strobe
  input wire logic evt,
  input wire logic clr,
  // Count
  output logic [W-1:0] count
);
  // Saturation keeps a flood of errors from reading as a small count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (clr) begin
      count <= W'(evt);
    end else if (evt && count != '1) begin
      count <= count + 1'b1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_cnt_clear: assert property (
    clr && !evt |=> count == '0)
    else $error("counter not cleared by read");
  chk_cnt_step: assert property (
    !clr && evt && count != '1 |=> count == W'($past(count) + 1'b1))
    else $error("counter did not count an error");
  chk_cnt_hold: assert property (
    !clr && !evt |=> count == $past(count))
    else $error("counter moved without an event");
  chk_cnt_saturate: assert property (
    !clr && count == '1 |=> count == '1)
    else $error("counter wrapped past all ones");
endmodule : ulm_err_counter
`default_nettype wire
